// [parallel_panel_interface.v]
// Parallel panel driver: strobe engine, panel clock divider, frame DMA and status flags.
// How it works
// - Type 100 runs character protocol, low byte.
// - Character mode: read/write line, register select.
// - Type 001: combined enable, select, 16 bits.
// - Type 011: separate read and write strobes.
// - Sync types drive panel clock on secondary.
// - Async types offer secondary select for display.
// - Timing comes from selected select's config.
// - Panel clock divided by divisor, zero passes.
// - DMA uses one or two ping-pong buffers.
// - DMA writes appear as ordinary bus writes.
// - Buffers bounded by start/end; unused ignored.
// - DMA starts only once enable is set.
// - One event per completed frame buffer.
// - Done enable gates the interrupt request.
// - Flags record events regardless of enable.
// - Flag with enable requests; write-one clears.
`timescale 1ns/10ps
`include "panel_driver_consts.vh"
module parallel_panel_interface #(
	parameter DATA_W   = 16,
	parameter ADDR_W   = 16,
	parameter FIFO_DEP = `FIFO_DEPTH_DEF
) (
	input  wire              core_clk,
	input  wire              nrst,
	input  wire [2:0]        controller_type_select,
	input  wire [7:0]        panel_clock_divisor,
	input  wire [11:0]       select0_timing_config,
	input  wire [11:0]       select1_timing_config,
	input  wire              dma_drive_enable,
	input  wire              dma_two_buffers,
	input  wire              dma_target_select,
	input  wire              dma_target_is_data,
	input  wire              done_int_enable,
	input  wire [ADDR_W-1:0] buffer0_start_addr,
	input  wire [ADDR_W-1:0] buffer0_end_addr,
	input  wire [ADDR_W-1:0] buffer1_start_addr,
	input  wire [ADDR_W-1:0] buffer1_end_addr,
	output reg  [ADDR_W-1:0] memAddr,
	output reg               memRead,
	input  wire [DATA_W-1:0] memData,
	input  wire              memDataValid,
	input  wire              cpuValid,
	output reg               cpuReady,
	input  wire              cpuWrite,
	input  wire              cpuIsData,
	input  wire              cpuSelect,
	input  wire [DATA_W-1:0] cpuWdata,
	output reg  [DATA_W-1:0] cpuRdata,
	output reg               cpuRdataValid,
	input  wire [2:0]        statusClear,
	output reg               buffer0_complete_flag,
	output reg               buffer1_complete_flag,
	output reg               doneFlag,
	output reg               panelIrq,
	output reg               panel_cmd_data_select,
	output reg               panel_rw_or_write_strobe,
	output reg               panel_enable_or_read_strobe,
	output reg               panel_primary_select,
	output reg               panel_secondary_select_or_clk,
	output reg  [DATA_W-1:0] panelDataOut,
	output reg               panelDataOe_n,
	input  wire [DATA_W-1:0] panelDataIn
);
	localparam AW = (FIFO_DEP <= 2) ? 1 : (FIFO_DEP <= 4) ? 2 : (FIFO_DEP <= 8) ? 3 : (FIFO_DEP <= 16) ? 4 : 5;
	localparam FW = DATA_W + 1;

	// Panel timing clock: one-cycle tick, every cycle when divisor is zero.
	reg  [7:0] divCount;
	reg        panelTick;
	reg        panelClkLevel;
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			divCount      <= 8'h00;
			panelTick     <= 1'b0;
			panelClkLevel <= 1'b0;
		end else if (panel_clock_divisor == `DIV_PASS || divCount >= panel_clock_divisor - 8'h01) begin
			divCount      <= 8'h00;
			panelTick     <= 1'b1;
			panelClkLevel <= ~panelClkLevel;
		end else begin
			divCount  <= divCount + 8'h01;
			panelTick <= 1'b0;
		end
	end

	// Pin inputs are synchronised before use.
	reg [DATA_W-1:0] dinMeta;
	reg [DATA_W-1:0] dinSync;
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dinMeta <= {DATA_W{1'h0}};
			dinSync <= {DATA_W{1'h0}};
		end else begin
			dinMeta <= panelDataIn;
			dinSync <= dinMeta;
		end
	end

	// DMA engine: fetches words into the FIFO.
	reg  [1:0]        dmaState;
	reg               curBuf;
	reg  [ADDR_W-1:0] fetchAddr;
	reg               fifoPush;
	reg  [FW-1:0]     fifoIn;
	reg               frameLast;
	wire              fifoInReady;
	wire              fifoOutValid;
	wire [FW-1:0]     fifoOut;
	reg               fifoPop;
	wire [ADDR_W-1:0] curEnd = curBuf ? buffer1_end_addr : buffer0_end_addr;

	word_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEP), .AW(AW)) dataFifo (
		.core_clk (core_clk),
		.nrst     (nrst),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.inData   (fifoIn),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOut)
	);

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dmaState  <= `DMA_OFF;
			curBuf    <= 1'b0;
			fetchAddr <= {ADDR_W{1'b0}};
			memAddr   <= {ADDR_W{1'b0}};
			memRead   <= 1'b0;
			fifoPush  <= 1'b0;
			fifoIn    <= {FW{1'b0}};
			frameLast <= 1'b0;
		end else begin
			memRead  <= 1'b0;
			fifoPush <= 1'b0;
			case (dmaState)
			`DMA_OFF: begin
				curBuf    <= 1'b0;
				// frame starts at buffer 0 base
				fetchAddr <= buffer0_start_addr;
				if (dma_drive_enable) begin
					dmaState <= `DMA_FETCH;
				end
			end
			`DMA_FETCH: begin
				if (!dma_drive_enable) begin
					dmaState <= `DMA_OFF;
				end else if (fifoInReady && !fifoPush) begin
					memAddr   <= fetchAddr;
					memRead   <= 1'b1;
					frameLast <= (fetchAddr == curEnd);
					dmaState  <= `DMA_WAIT;
				end
			end
			`DMA_WAIT: begin
				if (memDataValid) begin
					// DMA word is tagged with its last-word-of-buffer marker
					fifoPush <= 1'b1;
					fifoIn   <= {frameLast, memData};
					dmaState <= dma_drive_enable ? `DMA_FETCH : `DMA_OFF;
					if (frameLast) begin
						// second buffer ignored in single mode
						curBuf    <= dma_two_buffers ? ~curBuf : 1'b0;
						fetchAddr <= (dma_two_buffers && !curBuf) ? buffer1_start_addr : buffer0_start_addr;
					end else begin
						fetchAddr <= fetchAddr + 1'b1;
					end
				end
			end
			default: dmaState <= `DMA_OFF;
			endcase
		end
	end

	// Transfer engine: one transfer at a time in setup, strobe and hold phases.
	reg  [2:0]        busState;
	reg  [3:0]        phaseCount;
	reg               xferSel;
	reg               xferWrite;
	reg               xferData;
	reg               xferDma;
	reg               xferLast;
	reg               doneBuf;
	reg               curBufAtPop;
	reg  [DATA_W-1:0] xferWord;
	reg               frameEvent;
	wire [11:0]       cfg = xferSel ? select1_timing_config : select0_timing_config;
	wire [3:0]        tSetup = cfg[`CFG_SETUP_LSB +: `CFG_FIELD_W];
	wire [3:0]        tStrobe = cfg[`CFG_STROBE_LSB +: `CFG_FIELD_W];
	wire [3:0]        tHold = cfg[`CFG_HOLD_LSB +: `CFG_FIELD_W];
	wire              isChar = (controller_type_select == `TYPE_CHARACTER);
	wire              isStrobeType = controller_type_select[1];
	wire              isSync = !controller_type_select[0] && !isChar;
	wire              active = (busState == `ST_STROBE);
	wire [DATA_W-1:0] charWord = {{(DATA_W-8){1'b0}}, xferWord[`CHAR_BYTE_MSB:0]};

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			busState      <= `ST_IDLE;
			phaseCount    <= 4'h0;
			xferSel       <= 1'b0;
			xferWrite     <= 1'b0;
			xferData      <= 1'b0;
			xferDma       <= 1'b0;
			xferLast      <= 1'b0;
			xferWord      <= {DATA_W{1'b0}};
			cpuReady      <= 1'b0;
			cpuRdata      <= {DATA_W{1'b0}};
			cpuRdataValid <= 1'b0;
			fifoPop       <= 1'b0;
			frameEvent    <= 1'b0;
			doneBuf       <= 1'b0;
		end else begin
			cpuReady      <= 1'b0;
			cpuRdataValid <= 1'b0;
			fifoPop       <= 1'b0;
			frameEvent    <= 1'b0;
			case (busState)
			`ST_IDLE: begin
				phaseCount <= 4'h0;
				if (fifoOutValid && !fifoPop && dma_drive_enable) begin
					fifoPop   <= 1'b1;
					xferSel   <= dma_target_select;
					xferWrite <= 1'b1;
					xferData  <= dma_target_is_data;
					xferDma   <= 1'b1;
					xferLast  <= fifoOut[DATA_W];
					xferWord  <= fifoOut[DATA_W-1:0];
					doneBuf   <= curBufAtPop;
					busState  <= `ST_SETUP;
				end else if (cpuValid && !cpuReady && !dma_drive_enable) begin
					// address and data writes pass in program order
					xferSel   <= cpuSelect;
					xferWrite <= cpuWrite;
					xferData  <= cpuIsData;
					xferDma   <= 1'b0;
					xferLast  <= 1'b0;
					xferWord  <= cpuWdata;
					busState  <= `ST_SETUP;
				end
			end
			`ST_SETUP: begin
				if (panelTick) begin
					if (phaseCount >= tSetup) begin
						phaseCount <= 4'h0;
						busState   <= `ST_STROBE;
					end else begin
						phaseCount <= phaseCount + 4'h1;
					end
				end
			end
			`ST_STROBE: begin
				if (panelTick) begin
					if (phaseCount >= tStrobe) begin
						phaseCount <= 4'h0;
						busState   <= `ST_HOLD;
						if (!xferWrite) begin
							cpuRdata <= isChar ? {{(DATA_W-8){1'b0}}, dinSync[`CHAR_BYTE_MSB:0]} : dinSync;
						end
					end else begin
						phaseCount <= phaseCount + 4'h1;
					end
				end
			end
			`ST_HOLD: begin
				if (panelTick) begin
					if (phaseCount >= tHold) begin
						busState <= `ST_IDLE;
						if (!xferDma) begin
							cpuReady      <= 1'b1;
							cpuRdataValid <= !xferWrite;
						end
						frameEvent <= xferDma && xferLast;
					end else begin
						phaseCount <= phaseCount + 4'h1;
					end
				end
			end
			default: busState <= `ST_IDLE;
			endcase
		end
	end

	// Buffer that the word at the FIFO head belongs to.
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			curBufAtPop <= 1'b0;
		end else if (!dma_drive_enable) begin
			curBufAtPop <= 1'b0;
		end else if (fifoPop && fifoOut[DATA_W]) begin
			curBufAtPop <= dma_two_buffers ? ~curBufAtPop : 1'b0;
		end
	end

	// Pin drive, registered.
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			panel_cmd_data_select         <= 1'b0;
			panel_rw_or_write_strobe      <= 1'b0;
			panel_enable_or_read_strobe   <= 1'b0;
			panel_primary_select          <= 1'b0;
			panel_secondary_select_or_clk <= 1'b0;
			panelDataOut                  <= {DATA_W{1'b0}};
			panelDataOe_n                 <= 1'b1;
		end else begin
			panel_cmd_data_select <= (busState != `ST_IDLE) && xferData;
			panelDataOut          <= isChar ? charWord : xferWord;
			panelDataOe_n         <= !((busState != `ST_IDLE) && xferWrite);
			if (isChar) begin
				// character protocol on low byte, enable per display
				panel_rw_or_write_strobe      <= (busState != `ST_IDLE) && !xferWrite;
				panel_enable_or_read_strobe   <= 1'b0;
				panel_primary_select          <= active && !xferSel;
				panel_secondary_select_or_clk <= active && xferSel;
			end else if (isStrobeType) begin
				panel_rw_or_write_strobe    <= !(active && xferWrite);
				panel_enable_or_read_strobe <= !(active && !xferWrite);
				panel_primary_select        <= !((busState != `ST_IDLE) && !xferSel);
				// sync types put panel clock on secondary pin
				// async types keep a second chip select
				panel_secondary_select_or_clk <= isSync ? panelClkLevel : !((busState != `ST_IDLE) && xferSel);
			end else begin
				panel_rw_or_write_strobe      <= !xferWrite;
				panel_enable_or_read_strobe   <= active;
				panel_primary_select          <= !((busState != `ST_IDLE) && !xferSel);
				panel_secondary_select_or_clk <= isSync ? panelClkLevel : !((busState != `ST_IDLE) && xferSel);
			end
		end
	end

	// Status flags: a new event wins over a simultaneous clear.
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			buffer0_complete_flag <= 1'b0;
			buffer1_complete_flag <= 1'b0;
			doneFlag              <= 1'b0;
			panelIrq              <= 1'b0;
		end else begin
			buffer0_complete_flag <= (frameEvent && !doneBuf) || (buffer0_complete_flag && !statusClear[0]);
			buffer1_complete_flag <= (frameEvent && doneBuf) || (buffer1_complete_flag && !statusClear[1]);
			doneFlag              <= frameEvent || (doneFlag && !statusClear[2]);
			panelIrq <= done_int_enable && (buffer0_complete_flag || buffer1_complete_flag || doneFlag);
		end
	end
endmodule

// [panel_driver_consts.vh]
// Constants for the parallel panel driver.
`ifndef PANEL_DRIVER_CONSTS_VH
`define PANEL_DRIVER_CONSTS_VH
`define TYPE_SYNC_COMBINED   3'h0
`define TYPE_ASYNC_COMBINED  3'h1
`define TYPE_SYNC_STROBE     3'h2
`define TYPE_ASYNC_STROBE    3'h3
`define TYPE_CHARACTER       3'h4
`define DIV_PASS             8'h00
`define CFG_SETUP_LSB        0
`define CFG_STROBE_LSB       4
`define CFG_HOLD_LSB         8
`define CFG_FIELD_W          4
`define CHAR_BYTE_MSB        7
`define ST_IDLE              3'h0
`define ST_SETUP             3'h1
`define ST_STROBE            3'h2
`define ST_HOLD              3'h3
`define DMA_OFF              2'h0
`define DMA_FETCH            2'h1
`define DMA_WAIT             2'h2
`define FIFO_DEPTH_DEF       8
`endif

// [word_fifo.v]
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module word_fifo #(
	parameter WIDTH = 17,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             core_clk,
	input  wire             nrst,
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr;
	reg [AW-1:0]    rdPtr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign inReady  = (count != DEPTH[AW:0]);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// [panel_monitor.sv]
// Port-level assertions for the parallel panel driver.
`timescale 1ns/10ps
module panel_monitor #(
	parameter ADDR_W = 16,
	parameter DATA_W = 16
) (
	input wire logic              core_clk,
	input wire logic              nrst,
	input wire logic [2:0]        controller_type_select,
	input wire logic              dma_drive_enable,
	input wire logic              dma_two_buffers,
	input wire logic              done_int_enable,
	input wire logic [ADDR_W-1:0] buffer0_start_addr,
	input wire logic [ADDR_W-1:0] buffer0_end_addr,
	input wire logic [ADDR_W-1:0] buffer1_start_addr,
	input wire logic [ADDR_W-1:0] buffer1_end_addr,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic              memRead,
	input wire logic              cpuValid,
	input wire logic              cpuReady,
	input wire logic              cpuRdataValid,
	input wire logic [2:0]        statusClear,
	input wire logic              buffer0_complete_flag,
	input wire logic              buffer1_complete_flag,
	input wire logic              doneFlag,
	input wire logic              panelIrq,
	input wire logic [DATA_W-1:0] panelDataOut,
	input wire logic              panelDataOe_n
);
	wire inBuf0 = memAddr >= buffer0_start_addr && memAddr <= buffer0_end_addr;
	wire inBuf1 = memAddr >= buffer1_start_addr && memAddr <= buffer1_end_addr;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence dmaOff; !dma_drive_enable [*2]; endsequence
	sequence irqOff; !done_int_enable [*2]; endsequence
	sequence irqArmed; (done_int_enable && doneFlag) [*2]; endsequence
	sequence flagsLow; (!doneFlag && !buffer0_complete_flag && !buffer1_complete_flag) [*2]; endsequence
	a_ready_one_cycle: assert property (cpuReady |=> !cpuReady)
		else $error("cpuReady held longer than one cycle");
	a_ready_needs_req: assert property (cpuReady |-> cpuValid)
		else $error("cpuReady without a processor request");
	a_rdata_with_ready: assert property (cpuRdataValid |-> cpuReady)
		else $error("read data valid without cpuReady");
	a_char_low_byte: assert property (controller_type_select == 3'h4 && !panelDataOe_n |-> panelDataOut[15:8] == 8'h00)
		else $error("upper data bits driven in character mode");
	a_fetch_needs_enable: assert property (dmaOff |-> !memRead)
		else $error("frame fetch while DMA disabled");
	a_fetch_in_bounds: assert property (memRead |-> inBuf0 || (dma_two_buffers && inBuf1))
		else $error("frame fetch outside the active buffers");
	a_buf_flag_sticky: assert property (buffer0_complete_flag && !statusClear[0] |=> buffer0_complete_flag)
		else $error("buffer 0 flag lost without a clear");
	a_done_flag_sticky: assert property (doneFlag && !statusClear[2] |=> doneFlag)
		else $error("done flag lost without a clear");
	a_frame_sets_done: assert property ($rose(buffer0_complete_flag) || $rose(buffer1_complete_flag) |-> doneFlag)
		else $error("buffer flag set without the done flag");
	a_irq_gated_off: assert property (irqOff |-> !panelIrq)
		else $error("interrupt raised while its enable is low");
	a_irq_raised: assert property (irqArmed |-> panelIrq)
		else $error("interrupt missing with flag and enable set");
	a_irq_withdrawn: assert property (flagsLow |-> !panelIrq)
		else $error("interrupt held after flags cleared");
endmodule
bind parallel_panel_interface panel_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_panel_monitor (
	.core_clk(core_clk), .nrst(nrst), .controller_type_select(controller_type_select),
	.dma_drive_enable(dma_drive_enable), .dma_two_buffers(dma_two_buffers), .done_int_enable(done_int_enable),
	.buffer0_start_addr(buffer0_start_addr), .buffer0_end_addr(buffer0_end_addr),
	.buffer1_start_addr(buffer1_start_addr), .buffer1_end_addr(buffer1_end_addr),
	.memAddr(memAddr), .memRead(memRead), .cpuValid(cpuValid), .cpuReady(cpuReady),
	.cpuRdataValid(cpuRdataValid), .statusClear(statusClear), .buffer0_complete_flag(buffer0_complete_flag),
	.buffer1_complete_flag(buffer1_complete_flag), .doneFlag(doneFlag), .panelIrq(panelIrq),
	.panelDataOut(panelDataOut), .panelDataOe_n(panelDataOe_n));

// [panel_model.sv]
// Behavioural panel that logs written words and answers reads.
`timescale 1ns/10ps
module panel_model (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [2:0]  mode,
	input  wire logic        cmd,
	input  wire logic        rw,
	input  wire logic        en,
	input  wire logic        prim,
	input  wire logic        sec,
	input  wire logic [15:0] dOut,
	input  wire logic        dOe_n,
	input  wire logic [15:0] rdValue,
	output logic [15:0]      dIn
);
	logic [17:0] seen[$];
	logic [2:0]  pMode = 3'h0;
	logic        pRw = 1'b0, pEn = 1'b0, pPrim = 1'b0, pSec = 1'b0;
	logic [15:0] noise = 16'h0000;
	int          settle = 3;
	// read answer
	// A released bus shows a moving pattern, so stale data can never pass for an answer.
	// A character panel answers while its read/write line says read.
	assign dIn = ((mode == 3'h4) ? rw : (dOe_n && (!prim || !sec))) ? rdValue : noise;
	// Pins jump to new idle levels after reset or a mode change; those edges are not transfers.
	always @(posedge core_clk) begin
		noise <= noise + 16'h3C71;
		{pMode, pRw, pEn, pPrim, pSec} <= {mode, rw, en, prim, sec};
		if (!nrst || mode != pMode)
			settle <= 3;
		else if (settle > 0)
			settle <= settle - 1;
		else if (mode == 3'h4 && !rw && ((pPrim && !prim) || (pSec && !sec)))
			seen.push_back({pSec && !sec, cmd, dOut});
		else if (mode == 3'h1 && !rw && pEn && !en && !(prim && sec))
			seen.push_back({!sec, cmd, dOut});
		else if (mode == 3'h3 && !pRw && rw && !(prim && sec))
			seen.push_back({!sec, cmd, dOut});
	end
endmodule

// [lcd_parallel_panel_driver_test.sv]
// Self-checking bench: processor transfers per mode, panel clock, frame DMA and flags.
`timescale 1ns/10ps
module lcd_parallel_panel_driver_test;
	logic        core_clk = 0, nrst = 0, dmaEn = 0, twoBuf = 0, tgtSel = 0, tgtData = 0, intEn = 0, dmaMode = 0;
	logic        memRead, memDataValid = 0, cpuValid = 0, cpuWrite = 0, cpuIsData = 0, cpuSelect = 0, pSec = 0;
	logic        cpuReady, rdv, cpuRdataValid, f0, f1, fDone, panelIrq, cmdPin, rwPin, enPin, primPin, secPin, dataOe_n;
	logic [2:0]  typeSel = 3'h4, statusClear = 3'h0;
	logic [2:0]  modes[3] = '{3'h4, 3'h1, 3'h3};
	logic [7:0]  divisor = 8'h00;
	logic [11:0] cfg0 = 12'h222, cfg1 = 12'h222;
	logic [15:0] memAddr, memData = 16'h0000, cpuWdata = 16'h0000, cpuRdata, rd, dOut, dIn, rdValue = 16'h0000, v;
	logic [15:0] b0s = 16'h0010, b0e = 16'h0012, b1s = 16'h0020, b1e = 16'h0021, memq[$], dmaSeq[$];
	logic [17:0] w, expq[$];
	int          n_mismatch = 0, checked = 0, toggles = 0, k = 0, cyc = 0, memWait = 0;
	parallel_panel_interface i_parallel_panel_interface (
		.core_clk(core_clk), .nrst(nrst), .controller_type_select(typeSel), .panel_clock_divisor(divisor),
		.select0_timing_config(cfg0), .select1_timing_config(cfg1), .dma_drive_enable(dmaEn),
		.dma_two_buffers(twoBuf), .dma_target_select(tgtSel), .dma_target_is_data(tgtData), .done_int_enable(intEn),
		.buffer0_start_addr(b0s), .buffer0_end_addr(b0e), .buffer1_start_addr(b1s), .buffer1_end_addr(b1e),
		.memAddr(memAddr), .memRead(memRead), .memData(memData), .memDataValid(memDataValid),
		.cpuValid(cpuValid), .cpuReady(cpuReady), .cpuWrite(cpuWrite), .cpuIsData(cpuIsData), .cpuSelect(cpuSelect),
		.cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .cpuRdataValid(cpuRdataValid), .statusClear(statusClear),
		.buffer0_complete_flag(f0), .buffer1_complete_flag(f1), .doneFlag(fDone), .panelIrq(panelIrq),
		.panel_cmd_data_select(cmdPin), .panel_rw_or_write_strobe(rwPin), .panel_enable_or_read_strobe(enPin),
		.panel_primary_select(primPin), .panel_secondary_select_or_clk(secPin), .panelDataOut(dOut),
		.panelDataOe_n(dataOe_n), .panelDataIn(dIn));
	panel_model i_panel_model (.core_clk(core_clk), .nrst(nrst), .mode(typeSel), .cmd(cmdPin), .rw(rwPin),
		.en(enPin), .prim(primPin), .sec(secPin), .dOut(dOut), .dOe_n(dataOe_n), .rdValue(rdValue), .dIn(dIn));
	always #12.5 core_clk = ~core_clk;
	function automatic logic [15:0] memf(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, a[7:0]};
	endfunction
	function automatic logic [11:0] rndCfg();
		return 12'h222 | 12'($urandom & 32'h333);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cpu(input logic wr, input logic isData, input logic sel, input logic [15:0] val);
		@(negedge core_clk);
		{cpuValid, cpuWrite, cpuIsData, cpuSelect, cpuWdata} = {1'b1, wr, isData, sel, val};
		cyc = 0;
		while (cpuReady !== 1'b1 && cyc < 8000) begin
			@(negedge core_clk);
			cyc++;
		end
		{rd, rdv} = {cpuRdata, cpuRdataValid};
		@(negedge core_clk);
		cpuValid = 0;
	endtask
	task automatic timing(input logic [11:0] c);
		int d, s;
		d = (divisor == 8'h00) ? 1 : divisor;
		s = c[3:0] + c[7:4] + c[11:8] + 3;
		check(cyc >= d * (s - 1) + 2 && cyc <= d * s + 1, 1);
	endtask
	task automatic waitDone;
		cyc = 0;
		while (fDone !== 1'b1 && cyc < 4000) begin
			@(negedge core_clk);
			cyc++;
		end
	endtask
	// Frame memory answers in order after a random wait; between answers the data lines keep moving.
	always @(negedge core_clk) begin
		if (!nrst)
			memq.delete();
		else if (memRead === 1'b1)
			memq.push_back(memAddr);
		if (memq.size() > 0 && memWait == 0) begin
			memDataValid <= 1'b1;
			memData <= memf(memq.pop_front());
			memWait = $urandom % 3;
		end else begin
			memDataValid <= 1'b0;
			memData <= memData ^ 16'hA5C3;
			if (memWait > 0)
				memWait--;
		end
	end
	always @(negedge core_clk) begin
		if (secPin !== pSec)
			toggles++;
		pSec = secPin;
		while (i_panel_model.seen.size() > 0) begin
			w = i_panel_model.seen.pop_front();
			if (dmaMode) begin
				check(w, {tgtSel, tgtData, memf(dmaSeq[k])});
				k = (k + 1) % dmaSeq.size();
			end else
				check(w, expq.size() > 0 ? expq.pop_front() : ~w);
		end
	end
	initial begin
		void'($urandom(27));
		repeat (2) @(negedge core_clk);
		check({f0, f1, fDone, panelIrq, cpuReady, memRead, dataOe_n}, 7'h01);
		@(negedge core_clk);
		nrst = 1;
		for (int m = 0; m < 3; m++) begin
			typeSel = modes[m];
			cfg0 = rndCfg();
			cfg1 = rndCfg();
			repeat (4) @(negedge core_clk);
			for (int i = 0; i < 4; i++) begin
				v = $urandom;
				expq.push_back({i[0], i != 0, typeSel == 3'h4 ? {8'h00, v[7:0]} : v});
				cpu(1'b1, i != 0, i[0], v);
				timing(i[0] ? cfg1 : cfg0);
			end
		end
		for (int i = 0; i < 3; i++) begin
			typeSel = (i == 2) ? 3'h4 : 3'h1;
			rdValue = $urandom;
			cpu(1'b0, 1'b1, i[0], 16'h0000);
			check({rdv, rd}, {1'b1, i == 2 ? {8'h00, rdValue[7:0]} : rdValue});
		end
		typeSel = 3'h3;
		for (int i = 0; i < 2; i++) begin
			divisor = i ? 8'hFF : 8'h03;
			v = $urandom;
			expq.push_back({2'b01, v});
			cpu(1'b1, 1'b1, 1'b0, v);
			timing(cfg0);
		end
		divisor = 8'h02;
		for (int m = 0; m < 2; m++) begin
			typeSel = m ? 3'h2 : 3'h0;
			toggles = 0;
			cpu(1'b1, 1'b1, 1'b0, 16'h1234);
			check(toggles > 3, 1);
		end
		check(expq.size(), 0);
		{divisor, typeSel, tgtSel, tgtData, k, dmaMode} = {8'h00, 3'h1, 1'b1, 1'b1, 32'd0, 1'b1};
		dmaSeq = '{16'h0010, 16'h0011, 16'h0012};
		repeat (4) @(negedge core_clk);
		dmaEn = 1;
		waitDone;
		check({f0, f1, fDone, panelIrq}, 4'hA);
		intEn = 1;
		repeat (2) @(negedge core_clk);
		check(panelIrq, 1);
		statusClear = 3'h7;
		@(negedge core_clk);
		statusClear = 3'h0;
		repeat (2) @(negedge core_clk);
		check({f0, f1, fDone, panelIrq}, 4'h0);
		waitDone;
		check({f0, f1}, 2'b10);
		{dmaEn, nrst} = 2'b00;
		repeat (3) @(negedge core_clk);
		check({f0, f1, fDone}, 3'h0);
		{twoBuf, k, nrst} = {1'b1, 32'd0, 1'b1};
		dmaSeq = '{16'h0010, 16'h0011, 16'h0012, 16'h0020, 16'h0021};
		repeat (2) @(negedge core_clk);
		dmaEn = 1;
		waitDone;
		check({f0, f1}, 2'b10);
		statusClear = 3'h7;
		@(negedge core_clk);
		statusClear = 3'h0;
		waitDone;
		check({f0, f1}, 2'b01);
		tally_and_finish;
	end
	// The full run needs well under 20000 cycles; this limit only catches a hang.
	initial begin
		#1500000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule
